/* File: hw/dma_req_pkg.sv */
package dma_req_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned GATE_SHORT_NS = 350;
    localparam int unsigned GATE_LONG_NS = 750;
    // Gate times are least intervals, so round up
    localparam logic [6:0] GATE_SHORT_CYC =
        7'((GATE_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [6:0] GATE_LONG_CYC =
        7'((GATE_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // ----------------------------------------------------------------
    // Host register map
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_PTR_HIGH = 3'h2;
    localparam logic [2:0] ADDR_PTR_LOW = 3'h3;
    localparam logic [2:0] ADDR_SUB_ADDRESS = 3'h5;
    localparam logic [2:0] ADDR_CONFIG = 3'h6;
    localparam logic [2:0] ADDR_PAGED = 3'h7;
    localparam logic [2:0] PAGE_MODE_CONTROL = 3'h5;
    localparam logic [2:0] PAGE_LENGTH_SETTING = 3'h6;
    localparam int unsigned EXT_PAGE_BIT = 2;
    localparam int unsigned REQUEST_ENABLE_BIT = 3;
    localparam int unsigned SWAP_BIT = 0;
    localparam logic [7:0] MODE_CONTROL_RST = 8'h00;
    localparam logic [7:0] LENGTH_SETTING_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h18;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [2:0] PAGE_RST = 3'h0;

    // ----------------------------------------------------------------
    // Modes, states, data path
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_NON_BURST = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_PROG_TIMER = 2'h2;
    localparam logic [1:0] MODE_PROG_CYCLE = 2'h3;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BUF_DEPTH = 2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAIT_REFRESH = 5'h02,
        ST_RUN = 5'h04,
        ST_PAUSE = 5'h08,
        ST_GAP = 5'h10
    } dma_state_e;

    typedef struct packed {
        logic wide_access_enable;
        logic gate_time_select;
        logic tc_msb_refresh_sync;
        logic term_enable_retrigger;
        logic [1:0] transfer_mode_select;
        logic terminal_count_polarity;
        logic request_polarity;
    } mode_control_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage

/* File: hw/dma_request_control.sv */
`timescale 1ns/1ps
`default_nettype none

module dma_request_control
    import dma_req_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [DATA_W-1:0] ram_data,
    input wire logic ram_valid,
    output logic ram_ready,
    output logic dma_request_out,
    input wire logic dma_ack_in,
    input wire logic terminal_count_in,
    input wire logic refresh_indication_n,
    output logic [DATA_W-1:0] host_data,
    output logic host_data_valid,
    output logic dma_run_active
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    mode_control_s mode_q;
    logic [7:0] length_q;
    logic [7:0] ptr_high_q;
    logic [7:0] ptr_low_q;
    logic [7:0] config_q;
    logic [2:0] page_q;
    logic [7:0] reg_rdata_q;
    logic wr_paged;
    logic ptr_low_wr;
    logic start_ok;

    // Paged access
    // Page decode
    assign wr_paged = reg_req.wr && reg_req.addr == ADDR_PAGED;
    assign ptr_low_wr = reg_req.wr && reg_req.addr == ADDR_PTR_LOW;
    assign start_ok = ptr_high_q[REQUEST_ENABLE_BIT];

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_q <= MODE_CONTROL_RST;
            length_q <= LENGTH_SETTING_RST;
        end
        else if (clk_en && wr_paged)
        begin
            if (page_q == PAGE_MODE_CONTROL)
                mode_q <= reg_req.wdata;
            if (page_q == PAGE_LENGTH_SETTING)
                length_q <= reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ptr_high_q <= PTR_RST;
            ptr_low_q <= PTR_RST;
            config_q <= CONFIG_RST;
            page_q <= PAGE_RST;
        end
        else if (clk_en && reg_req.wr)
        begin
            case (reg_req.addr)
                ADDR_PTR_HIGH: ptr_high_q <= reg_req.wdata;
                ADDR_PTR_LOW: ptr_low_q <= reg_req.wdata;
                ADDR_SUB_ADDRESS: page_q <= reg_req.wdata[2:0];
                ADDR_CONFIG:
                begin
                    config_q <= reg_req.wdata;
                    page_q <= {1'b0, reg_req.wdata[1:0]};
                end
                default: ;
            endcase
        end
    end

    // Read data held until the next read
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata_q <= 8'h00;
        else if (clk_en && reg_req.rd)
        begin
            case (reg_req.addr)
                ADDR_PTR_HIGH: reg_rdata_q <= ptr_high_q;
                ADDR_PTR_LOW: reg_rdata_q <= ptr_low_q;
                ADDR_SUB_ADDRESS: reg_rdata_q <= {5'h00, page_q};
                ADDR_CONFIG: reg_rdata_q <= {config_q[7:2], page_q[1:0]};
                ADDR_PAGED:
                    if (page_q == PAGE_MODE_CONTROL)
                        reg_rdata_q <= mode_q;
                    else if (page_q == PAGE_LENGTH_SETTING)
                        reg_rdata_q <= length_q;
                    else
                        reg_rdata_q <= 8'h00;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end
    assign reg_rdata = reg_rdata_q;

    // ----------------------------------------------------------------
    // Two-entry buffer
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] entry_q [BUF_DEPTH];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] fill_q;
    logic [DATA_W-1:0] fmt_word;
    logic push;
    logic pop;
    logic req_active;
    dma_state_e state_q;
    dma_state_e state_d;

    always_comb
    begin
        if (!mode_q.wide_access_enable)
            fmt_word = {8'h00, ram_data[7:0]};
        else if (ptr_low_q[SWAP_BIT])
            fmt_word = {ram_data[7:0], ram_data[15:8]};
        else
            fmt_word = ram_data;
    end

    // Full buffer stalls the RAM side, so a slow controller drops nothing
    assign ram_ready = fill_q != 2'(BUF_DEPTH);
    assign push = ram_valid && ram_ready;
    assign host_data_valid = fill_q != 2'h0;
    assign req_active = state_q == ST_RUN && host_data_valid;
    assign pop = dma_ack_in && req_active;

    for (genvar i = 0; i < BUF_DEPTH; i++)
    begin : g_entry
        always_ff @(posedge ref_clk or posedge sys_rst)
        begin
            if (sys_rst)
                entry_q[i] <= 16'h0000;
            else if (clk_en && push && wr_ptr_q == 1'(i))
                entry_q[i] <= fmt_word;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            fill_q <= 2'h0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_ptr_q <= !wr_ptr_q;
            if (pop)
                rd_ptr_q <= !rd_ptr_q;
            if (push && !pop)
                fill_q <= fill_q + 2'h1;
            else if (pop && !push)
                fill_q <= fill_q - 2'h1;
        end
    end
    assign host_data = entry_q[rd_ptr_q];

    // ----------------------------------------------------------------
    // Request sequencer
    // ----------------------------------------------------------------
    logic [8:0] xfer_cnt_q;
    logic [7:0] burst_cnt_q;
    logic [6:0] gate_cnt_q;
    logic refresh_prev_q;
    logic refresh_fall;
    logic prog_mode;
    logic tc_active;
    logic ext_end;
    logic int_end;
    logic burst_end;
    logic gate_done;
    logic [6:0] gate_limit;

    assign prog_mode = mode_q.transfer_mode_select[1];
    assign refresh_fall = refresh_prev_q && !refresh_indication_n;
    assign tc_active = terminal_count_in == mode_q.terminal_count_polarity;
    assign ext_end = pop && tc_active;
    assign int_end = !prog_mode && mode_q.term_enable_retrigger && pop
        && xfer_cnt_q + 9'h001 == {mode_q.tc_msb_refresh_sync, length_q};
    assign gate_limit = mode_q.gate_time_select ? GATE_LONG_CYC - 7'h01
        : GATE_SHORT_CYC - 7'h01;
    assign gate_done = gate_cnt_q == gate_limit;

    always_comb
    begin
        case (mode_q.transfer_mode_select)
            MODE_PROG_TIMER: burst_end = burst_cnt_q == length_q;
            MODE_PROG_CYCLE: burst_end = pop && burst_cnt_q + 8'h01 == length_q;
            default: burst_end = 1'b0;
        endcase
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: ;
            ST_WAIT_REFRESH:
                if (refresh_fall)
                    state_d = ST_RUN;
            ST_RUN:
                if (ext_end || int_end)
                    state_d = ST_IDLE;
                else if (burst_end)
                    state_d = ST_GAP;
                else if (pop && mode_q.transfer_mode_select == MODE_NON_BURST)
                    state_d = ST_PAUSE;
            ST_PAUSE: state_d = ST_RUN;
            ST_GAP:
                if (mode_q.term_enable_retrigger ? gate_done : refresh_fall)
                    state_d = ST_RUN;
            default: state_d = ST_IDLE;
        endcase
        if (ptr_low_wr)
            if (!start_ok)
                state_d = ST_IDLE;
            else if (prog_mode && mode_q.tc_msb_refresh_sync)
                state_d = ST_WAIT_REFRESH;
            else
                state_d = ST_RUN;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_q <= ST_IDLE;
        else if (clk_en)
            state_q <= state_d;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            xfer_cnt_q <= 9'h000;
        else if (clk_en)
            if (ptr_low_wr)
                xfer_cnt_q <= 9'h000;
            else if (pop)
                xfer_cnt_q <= xfer_cnt_q + 9'h001;
    end

    // Burst counter counts clocks when timed, transfers when counted
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            burst_cnt_q <= 8'h00;
        else if (clk_en)
            if (state_q != ST_RUN)
                burst_cnt_q <= 8'h00;
            else if (mode_q.transfer_mode_select == MODE_PROG_TIMER || pop)
                burst_cnt_q <= burst_cnt_q + 8'h01;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gate_cnt_q <= 7'h00;
            refresh_prev_q <= 1'b1;
        end
        else if (clk_en)
        begin
            refresh_prev_q <= refresh_indication_n;
            if (state_q != ST_GAP)
                gate_cnt_q <= 7'h00;
            else
                gate_cnt_q <= gate_cnt_q + 7'h01;
        end
    end

    assign dma_request_out = req_active ~^ mode_q.request_polarity;
    assign dma_run_active = state_q != ST_IDLE;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_REQ_IDLE_LEVEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q != ST_RUN |-> dma_request_out == !mode_q.request_polarity)
        else $error("request pin active outside a run");
    AST_EXT_TC_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !ptr_low_wr && ext_end |=> state_q == ST_IDLE)
        else $error("terminal count did not end the run");
    AST_INT_TC_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !ptr_low_wr && state_q == ST_RUN && !prog_mode
        && mode_q.term_enable_retrigger && pop
        && xfer_cnt_q == {mode_q.tc_msb_refresh_sync, length_q} - 9'h001
        |=> state_q == ST_IDLE && dma_request_out == !mode_q.request_polarity)
        else $error("internal count did not end the run");
    AST_EXT_ONLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !ptr_low_wr && !prog_mode && !mode_q.term_enable_retrigger
        && pop && !tc_active |=> state_q != ST_IDLE)
        else $error("run ended without external terminal count");
    AST_REFRESH_RETRIG: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !ptr_low_wr && state_q == ST_GAP && !mode_q.term_enable_retrigger
        && $past(refresh_indication_n) && !refresh_indication_n |=> state_q == ST_RUN)
        else $error("refresh edge did not re-trigger");
    AST_TIMER_RETRIG: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !ptr_low_wr && state_q == ST_GAP && mode_q.term_enable_retrigger
        && gate_cnt_q == (mode_q.gate_time_select ? GATE_LONG_CYC : GATE_SHORT_CYC) - 7'h01
        |=> state_q == ST_RUN)
        else $error("gate timer re-trigger wrong length");
    AST_TIMED_BURST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !ptr_low_wr && state_q == ST_RUN && !ext_end
        && mode_q.transfer_mode_select == MODE_PROG_TIMER && burst_cnt_q == length_q
        |=> state_q == ST_GAP)
        else $error("timed burst not withdrawn");
    AST_CYCLE_BURST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !ptr_low_wr && !ext_end && pop
        && mode_q.transfer_mode_select == MODE_PROG_CYCLE
        && burst_cnt_q == length_q - 8'h01 |=> state_q == ST_GAP)
        else $error("counted burst not withdrawn");
    AST_SYNC_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && ptr_low_wr && start_ok && prog_mode && mode_q.tc_msb_refresh_sync
        |=> state_q == ST_WAIT_REFRESH && dma_request_out == !mode_q.request_polarity)
        else $error("refresh sync start not held");
    AST_PAGE_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && reg_req.wr && reg_req.addr == ADDR_CONFIG |=> !page_q[EXT_PAGE_BIT])
        else $error("config write left extended page set");
    AST_START_GATED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && ptr_low_wr && !start_ok |=> state_q == ST_IDLE)
        else $error("request started while disabled");
    AST_NARROW_DATA: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && push && !mode_q.wide_access_enable && fill_q == 2'h0
        |=> host_data == {8'h00, $past(ram_data[7:0])})
        else $error("narrow transfer carried upper byte");
    COV_NON_BURST: cover property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_PAUSE ##1 state_q == ST_RUN);
    COV_TIMER_RETRIG: cover property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_GAP && mode_q.term_enable_retrigger ##1 state_q == ST_RUN);
    COV_SYNC_START: cover property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_WAIT_REFRESH ##1 state_q == ST_RUN);
    COV_BUF_FULL: cover property (@(posedge ref_clk) disable iff (sys_rst)
        !ram_ready && state_q == ST_RUN);

endmodule

`default_nettype wire

/* File: verif/dma_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// System DMA controller model
// ------------------------------------------------
module dma_ctrl_model
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic dma_request_out,
    input wire logic req_pol,
    input wire logic tc_pol,
    input wire logic stall,
    input wire logic [9:0] tc_at,
    output logic dma_ack_in,
    output logic terminal_count_in
);
    logic [9:0] acks_q;
    logic active;

    assign active = (dma_request_out == req_pol);

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            dma_ack_in <= 1'b0;
        else
            dma_ack_in <= active && !stall;
    end

    // Counts accepted acks only, stale ones are ignored
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            acks_q <= 10'h000;
        else if (dma_ack_in && active)
            acks_q <= acks_q + 10'h001;
    end

    assign terminal_count_in = (dma_ack_in && (acks_q + 10'h001 == tc_at)) ? tc_pol : !tc_pol;
endmodule

`default_nettype wire

/* File: verif/host_dma_request_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module host_dma_request_control_bench;
    import dma_req_pkg::*;

    // ------------------------------------------------
    // Signals and model state
    // ------------------------------------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_s reg_req = '0;
    logic [7:0] reg_rdata;
    logic [DATA_W-1:0] ram_data = '0;
    logic ram_valid = 1'b0;
    logic ram_ready;
    logic dma_request_out;
    logic dma_ack_in;
    logic terminal_count_in;
    logic refresh_n = 1'b1;
    logic [DATA_W-1:0] host_data;
    logic host_data_valid;
    logic dma_run_active;
    logic req_pol = 1'b0;
    logic tc_pol = 1'b0;
    logic stall = 1'b0;
    logic stall_en = 1'b0;
    logic src_en = 1'b0;
    logic src_full = 1'b0;
    logic [9:0] tc_at = '0;
    logic [31:0] lfsr = 32'h000162D7;
    logic cur_wide = 1'b0;
    logic cur_swap = 1'b0;
    int num_errors = 0;
    int compares = 0;
    int n_acc = 0;
    logic [15:0] exp_q[$];

    always #4 ref_clk = ~ref_clk;

    dma_request_control DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .ram_data(ram_data), .ram_valid(ram_valid),
        .ram_ready(ram_ready), .dma_request_out(dma_request_out), .dma_ack_in(dma_ack_in),
        .terminal_count_in(terminal_count_in), .refresh_indication_n(refresh_n),
        .host_data(host_data), .host_data_valid(host_data_valid),
        .dma_run_active(dma_run_active));

    dma_ctrl_model partner (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .dma_request_out(dma_request_out), .req_pol(req_pol), .tc_pol(tc_pol), .stall(stall),
        .tc_at(tc_at), .dma_ack_in(dma_ack_in), .terminal_count_in(terminal_count_in));

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] exp_word(input logic [15:0] d);
        if (!cur_wide)
            return {8'h00, d[7:0]};
        return cur_swap ? {d[7:0], d[15:8]} : d;
    endfunction

    task automatic test_done();
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_int(input int got, input int exp);
        compares++;
        if (got != exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Source words and stall come from one shared sequence
    always @(posedge ref_clk)
    begin
        #1;
        lfsr = lfsr_next(lfsr);
        ram_valid = src_en && (lfsr[3] || src_full);
        ram_data = lfsr[15:0];
        stall = stall_en && lfsr[7];
    end

    // Reference queue checked at every accepted transfer
    always @(posedge ref_clk)
    begin
        if (!sys_rst && ram_valid && ram_ready)
            exp_q.push_back(exp_word(ram_data));
        if (!sys_rst && dma_ack_in && dma_request_out === req_pol)
        begin
            n_acc++;
            cmp16(host_data, exp_q.pop_front());
        end
    end

    task automatic reset_dut();
        sys_rst = 1'b1;
        src_en = 1'b0;
        req_pol = 1'b0;
        tc_pol = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        exp_q.delete();
        n_acc = 0;
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        #1 reg_req = '0;
    endtask

    task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        #1 reg_req = '0;
        cmp16({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task automatic set_page(input logic [2:0] p, input logic [7:0] d);
        wr_reg(ADDR_SUB_ADDRESS, {5'h00, p});
        wr_reg(ADDR_PAGED, d);
    endtask

    // Configure, fill the buffer while idle, then start
    task automatic start(input logic [7:0] mc, input logic [7:0] len, input logic swap);
        reset_dut();
        set_page(PAGE_MODE_CONTROL, mc);
        req_pol = mc[0];
        tc_pol = mc[1];
        set_page(PAGE_LENGTH_SETTING, len);
        cur_wide = mc[7];
        cur_swap = 1'b0;
        src_en = 1'b1;
        wr_reg(ADDR_PTR_LOW, 8'h00);
        repeat (6) @(posedge ref_clk);
        #1 cmp16({15'h0000, ram_ready}, 16'h0000);
        cmp16({15'h0000, host_data_valid}, 16'h0001);
        cmp16({15'h0000, dma_run_active}, 16'h0000);
        cmp16({15'h0000, dma_request_out}, {15'h0000, !mc[0]});
        wr_reg(ADDR_PTR_HIGH, 8'h08);
        wr_reg(ADDR_PTR_LOW, {7'h00, swap});
        cur_swap = swap;
    endtask

    task automatic term_run(input logic [7:0] mc, input logic [7:0] len, input int tca,
        input int exp);
        int i;
        tc_at = tca[9:0];
        stall_en = 1'b1;
        src_full = 1'b1;
        start(mc, len, 1'b1);
        src_full = 1'b0;
        for (i = 0; i < 3000 && dma_run_active !== 1'b0; i++)
            @(posedge ref_clk) #1;
        cmp_int(n_acc, exp);
        cmp16({15'h0000, dma_run_active}, 16'h0000);
        cmp16({15'h0000, dma_request_out}, {15'h0000, !mc[0]});
    endtask

    task automatic burst_run(input logic [7:0] mc, input logic [7:0] len, input int glo);
        int i;
        int a0;
        int n_act;
        int gap;
        tc_at = '0;
        stall_en = 1'b0;
        src_full = 1'b1;
        start(mc, len, 1'b0);
        for (i = 0; i < 50 && dma_request_out !== mc[0]; i++)
        begin
            if (i == 10)
                refresh_n = 1'b0;
            @(posedge ref_clk) #1;
        end
        refresh_n = 1'b1;
        cmp_int(i, mc[5] ? 11 : 0);
        a0 = n_acc;
        n_act = 0;
        gap = 0;
        for (i = 0; i < 600 && dma_request_out === mc[0]; i++)
        begin
            n_act++;
            @(posedge ref_clk) #1;
        end
        for (i = 0; i < 300 && dma_request_out !== mc[0]; i++)
        begin
            gap++;
            if (gap == 30 && !mc[4])
                refresh_n = 1'b0;
            @(posedge ref_clk) #1;
        end
        refresh_n = 1'b1;
        if (mc[3:2] == MODE_PROG_TIMER)
            cmp_int(n_act, len + 1);
        else
            cmp_int(n_acc - a0, len);
        cmp_int(gap >= glo && gap <= glo + 3, 1);
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        reset_dut();
        chk_reg(ADDR_CONFIG, CONFIG_RST);
        set_page(PAGE_MODE_CONTROL, 8'hA4);
        chk_reg(ADDR_PAGED, 8'hA4);
        set_page(PAGE_LENGTH_SETTING, 8'h3C);
        chk_reg(ADDR_PAGED, 8'h3C);
        wr_reg(ADDR_CONFIG, CONFIG_RST);
        chk_reg(ADDR_PAGED, 8'h00);
        term_run(8'h10, 8'h03, 0, 3);
        term_run(8'h97, 8'h04, 0, 4);
        term_run(8'h05, 8'h02, 5, 5);
        term_run(8'h12, 8'h09, 2, 2);
        term_run(8'h32, 8'h01, 0, 257);
        burst_run(8'h0C, 8'h05, 30);
        burst_run(8'h2C, 8'h05, 30);
        burst_run(8'h1C, 8'h05, GATE_SHORT_CYC);
        burst_run(8'h5C, 8'h05, GATE_LONG_CYC);
        burst_run(8'h18, 8'h07, GATE_SHORT_CYC);
        test_done();
    end

    // Generous bound over all runs
    initial
    begin
        #600000;
        num_errors++;
        test_done();
    end
endmodule

`default_nettype wire
